// ===== cdm_pkg.sv
/*
 * constants, state encoding and the state record of the core debug mode control.
 * assumes a single 200 mhz core clock and a 32-bit apb register port.
 */
package cdm_pkg;

	// ***************************************************************
	// widths
	// ***************************************************************
	localparam int unsigned XLEN   = 32;            // data and address width
	localparam int unsigned ADDR_W = 8;             // apb byte address width
	localparam int unsigned ID_W   = 5;             // interrupt index width

	// ***************************************************************
	// apb byte offsets, one aligned word each
	// ***************************************************************
	localparam logic [ADDR_W-1:0] OFS_TRAP_STATUS   = 8'h00;  // global enable, previous enable
	localparam logic [ADDR_W-1:0] OFS_TRAP_VECTOR   = 8'h04;  // vector base and mode
	localparam logic [ADDR_W-1:0] OFS_TRAP_PC       = 8'h08;  // saved trap pc
	localparam logic [ADDR_W-1:0] OFS_TRAP_CAUSE    = 8'h0c;  // trap_cause
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 8'h10;  // individual interrupt enables
	localparam logic [ADDR_W-1:0] OFS_DBG_CTRL      = 8'h14;  // debug control/status
	localparam logic [ADDR_W-1:0] OFS_DBG_PC        = 8'h18;  // debug saved pc
	localparam logic [ADDR_W-1:0] OFS_DBG_SCRATCH0  = 8'h1c;  // debug scratch 0
	localparam logic [ADDR_W-1:0] OFS_DBG_SCRATCH1  = 8'h20;  // debug scratch 1
	localparam logic [ADDR_W-1:0] OFS_TRIG_FIRST    = 8'h24;  // trigger_data_first
	localparam logic [ADDR_W-1:0] OFS_TRIG_SECOND   = 8'h28;  // trigger_data_second
	localparam logic [ADDR_W-1:0] OFS_DBG_STATE     = 8'h2c;  // read-only debug state

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int unsigned BIT_GIE        = 3;     // global interrupt enable
	localparam int unsigned BIT_PGIE       = 7;     // previous global enable
	localparam int unsigned BIT_VEC_MODE   = 0;     // vectored interrupt mode
	localparam int unsigned VEC_ALIGN      = 8;     // vector base aligned to 256 bytes
	localparam int unsigned BIT_BRK_DBG    = 15;    // breakpoint_to_debug
	localparam int unsigned DCAUSE_LSB     = 6;     // debug entry cause field
	localparam int unsigned DCAUSE_W       = 3;
	localparam logic [1:0]  DBG_PRV_M      = 2'h3;  // privilege field reads machine
	localparam int unsigned TRIG_TYPE_LSB  = 28;    // trigger type field
	localparam logic [3:0]  TRIG_TYPE_ADDR = 4'h2;  // address match type
	localparam int unsigned BIT_TRIG_DBG   = 27;    // trigger_debug_only, constant one
	localparam int unsigned BIT_TRIG_EXEC  = 2;     // execute address match enable
	localparam int unsigned BIT_CAUSE_IRQ  = 31;    // interrupt flag of trap_cause
	localparam int unsigned IRQ_STEP_SH    = 2;     // vectored stride of four bytes

	// ***************************************************************
	// codes and reset values
	// ***************************************************************
	localparam logic [DCAUSE_W-1:0] DCAUSE_EBREAK  = 3'h1;
	localparam logic [DCAUSE_W-1:0] DCAUSE_TRIGGER = 3'h2;
	localparam logic [DCAUSE_W-1:0] DCAUSE_HALTREQ = 3'h3;
	localparam logic [ID_W-1:0]     EXC_BREAKPOINT = 5'h03;
	localparam logic [XLEN-1:0]     ZERO_WORD      = 32'h0000_0000;

	// ***************************************************************
	// timing: availability delay after the fetch permit is seen
	// ***************************************************************
	localparam int unsigned BOOT_NS     = 10;
	localparam int unsigned CLK_MHZ     = 200;
	localparam int unsigned BOOT_CYCLES = (BOOT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0]  BOOT_LAST   = 2'(BOOT_CYCLES - 1);

	// ***************************************************************
	// debug state
	// ***************************************************************
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,   // reset seen, waiting for fetch permit
		ST_BOOT  = 2'b01,   // fetch permitted, still unavailable
		ST_RUN   = 2'b10,   // running
		ST_HALT  = 2'b11    // halted in debug mode
	} cdm_state_t;

	// complete state record of the controller
	typedef struct packed {
		cdm_state_t          st;          // debug state
		logic [1:0]          boot_cnt;    // availability delay
		logic                req_seen;    // halt request seen while unavailable
		logic                gie;         // global interrupt enable
		logic                pgie;        // previous global enable
		logic [XLEN-1:0]     tvec;        // trap vector base and mode
		logic [XLEN-1:0]     tpc;         // saved trap pc
		logic [XLEN-1:0]     tcause;      // trap_cause
		logic [XLEN-1:0]     irq_mask;    // individual interrupt enables
		logic                brk_dbg;     // breakpoint_to_debug
		logic [DCAUSE_W-1:0] dcause;      // debug entry cause
		logic [XLEN-1:0]     dpc;         // debug saved pc
		logic [XLEN-1:0]     scratch0;    // debug scratch 0
		logic [XLEN-1:0]     scratch1;    // debug scratch 1
		logic                trig_en;     // trigger armed
		logic [XLEN-1:0]     trig_addr;   // trigger_data_second
		logic                redirect;    // fetch redirect pulse
		logic [XLEN-1:0]     target;      // fetch redirect target
		logic                irq_ack;     // interrupt taken pulse
		logic [ID_W-1:0]     irq_id;      // taken interrupt index
		logic [XLEN-1:0]     prdata;      // apb read data
		logic                pslverr;     // apb error
	} cdm_regs_t;

endpackage

// ===== cdm_debug_ctrl.sv
/*
 * core debug mode control: debug state, debug entry and exit, trap entry and
 * return, one instruction address trigger and the apb register port.
 * assumes the pipeline presents one decoded instruction with its pc and
 * classification flags, synchronous to ref_clk, and obeys fetch redirects.
 */
// Summary of operation
// RL1: trap entry clears the global interrupt enable
// RL2: no hardware nesting; software re-enables for nesting
// RL3: debug entry saves pc, cause, fetches halt address
// RL4: enter debug on request, trigger, enabled breakpoint
// RL5: one trigger, instruction address match enters debug
// RL6: no illegal for buffer transfers or pc use
// RL7: halt request synchronous, held one clock at least
// RL8: decode instruction at first request cycle squashed
// RL9: exactly one of reset, running, halted high
// RL10: reset status falls after release and permit
// RL11: after reset, halted in debug, running otherwise
// RL12: early halt request goes straight to halted
// RL13: halt request while running halts within cycles
// RL14: breakpoint in debug restarts halt address, unchanged
// RL15: debug exception or return goes to trap address
// RL16: both debug addresses supplied word aligned
// RL17: four debug registers, illegal outside debug mode
// RL18: trigger debug-only reads one; writes gated
// RL19: breakpoint without debug bit traps to vector
// RL20: breakpoint with debug bit enters debug mode
// RL21: breakpoint_to_debug resets zero, set in debug
// RL22: software steps saved pc past the breakpoint
// RL23: trap saves pc and enable; return restores both
// RL24: interrupts ignored while in debug mode
// RL25: debug return resumes at saved pc, running
`timescale 1ns/1ps

module cdm_debug_ctrl (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      fetch_enable,
	input  wire logic                      debug_req,
	input  wire logic [cdm_pkg::XLEN-1:0]  halt_entry_address,
	input  wire logic [cdm_pkg::XLEN-1:0]  debug_trap_address,
	input  wire logic                      instr_valid,
	input  wire logic [cdm_pkg::XLEN-1:0]  instr_pc,
	input  wire logic                      instr_ebreak,
	input  wire logic                      instr_mret,
	input  wire logic                      instr_uret,
	input  wire logic                      instr_dret,
	input  wire logic                      instr_exc,
	input  wire logic [cdm_pkg::ID_W-1:0]  instr_exc_code,
	input  wire logic [cdm_pkg::XLEN-1:0]  irq_lines,
	output logic                           instr_kill,
	output logic                           fetch_redirect,
	output logic [cdm_pkg::XLEN-1:0]       fetch_target,
	output logic                           irq_ack,
	output logic [cdm_pkg::ID_W-1:0]       irq_id,
	output logic                           debug_havereset,
	output logic                           debug_running,
	output logic                           debug_halted,
	output logic                           irq_global_enable,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [cdm_pkg::ADDR_W-1:0] paddr,
	input  wire logic [cdm_pkg::XLEN-1:0]  pwdata,
	output logic [cdm_pkg::XLEN-1:0]       prdata,
	output logic                           pready,
	output logic                           pslverr
);

	// ***************************************************************
	// decode helpers
	// ***************************************************************

	// registers that exist only for the debugger
	function automatic logic is_dbg_reg(input logic [cdm_pkg::ADDR_W-1:0] a);
		is_dbg_reg = (a == cdm_pkg::OFS_DBG_CTRL) || (a == cdm_pkg::OFS_DBG_PC) ||
			(a == cdm_pkg::OFS_DBG_SCRATCH0) || (a == cdm_pkg::OFS_DBG_SCRATCH1);
	endfunction

	// every mapped offset
	function automatic logic is_mapped(input logic [cdm_pkg::ADDR_W-1:0] a);
		is_mapped = is_dbg_reg(a) || (a == cdm_pkg::OFS_TRAP_STATUS) ||
			(a == cdm_pkg::OFS_TRAP_VECTOR) || (a == cdm_pkg::OFS_TRAP_PC) ||
			(a == cdm_pkg::OFS_TRAP_CAUSE) || (a == cdm_pkg::OFS_IRQ_MASK) ||
			(a == cdm_pkg::OFS_TRIG_FIRST) || (a == cdm_pkg::OFS_TRIG_SECOND) ||
			(a == cdm_pkg::OFS_DBG_STATE);
	endfunction

	// highest numbered pending line wins
	function automatic logic [cdm_pkg::ID_W-1:0] irq_pick(input logic [cdm_pkg::XLEN-1:0] p);
		logic [cdm_pkg::ID_W-1:0] id;
		id = '0;
		for (int i = 0; i < cdm_pkg::XLEN; i++) begin
			if (p[i]) begin
				id = cdm_pkg::ID_W'(i);
			end
		end
		irq_pick = id;
	endfunction

	// ***************************************************************
	// state
	// ***************************************************************
	cdm_pkg::cdm_regs_t r_reg;                  // registered state
	cdm_pkg::cdm_regs_t r_next;                 // next state

	logic                     in_dbg;           // currently halted
	logic                     acc_setup;        // apb setup phase
	logic                     acc_wr;           // apb write access phase
	logic                     wr_ok;            // write allowed
	logic [cdm_pkg::XLEN-1:0] irq_pend;         // enabled pending lines
	logic                     trig_hit;         // trigger matches decode pc
	logic [cdm_pkg::XLEN-1:0] vec_base;         // aligned vector base
	logic [cdm_pkg::XLEN-1:0] rd_val;           // read mux
	logic [cdm_pkg::XLEN-1:0] dbg_ctrl_val;     // debug control/status view
	logic [cdm_pkg::XLEN-1:0] trig_first_val;   // trigger_data_first view
	logic [cdm_pkg::XLEN-1:0] status_val;       // trap status view

	assign in_dbg    = (r_reg.st == cdm_pkg::ST_HALT);
	assign acc_setup = psel && !penable;
	assign acc_wr    = psel && penable && pwrite;
	// debug registers refuse access outside debug mode
	assign wr_ok     = acc_wr && is_mapped(paddr) && !(is_dbg_reg(paddr) && !in_dbg); // RL17
	// interrupts only count while running
	assign irq_pend  = irq_lines & r_reg.irq_mask; // RL24
	assign trig_hit  = r_reg.trig_en && instr_valid && (instr_pc == r_reg.trig_addr); // RL5
	assign vec_base  = {r_reg.tvec[cdm_pkg::XLEN-1:cdm_pkg::VEC_ALIGN],
		cdm_pkg::VEC_ALIGN'(0)};

	// read views with constant fields filled in
	always_comb begin
		dbg_ctrl_val = cdm_pkg::ZERO_WORD;
		dbg_ctrl_val[cdm_pkg::BIT_BRK_DBG] = r_reg.brk_dbg;
		dbg_ctrl_val[cdm_pkg::DCAUSE_LSB +: cdm_pkg::DCAUSE_W] = r_reg.dcause;
		dbg_ctrl_val[1:0] = cdm_pkg::DBG_PRV_M;
		trig_first_val = cdm_pkg::ZERO_WORD;
		trig_first_val[cdm_pkg::TRIG_TYPE_LSB +: 4] = cdm_pkg::TRIG_TYPE_ADDR;
		trig_first_val[cdm_pkg::BIT_TRIG_DBG] = 1'b1; // RL18
		trig_first_val[cdm_pkg::BIT_TRIG_EXEC] = r_reg.trig_en;
		status_val = cdm_pkg::ZERO_WORD;
		status_val[cdm_pkg::BIT_GIE] = r_reg.gie;
		status_val[cdm_pkg::BIT_PGIE] = r_reg.pgie;
	end

	// read mux; debug registers read zero and error outside debug mode
	always_comb begin
		unique case (paddr)
			cdm_pkg::OFS_TRAP_STATUS:  rd_val = status_val;
			cdm_pkg::OFS_TRAP_VECTOR:  rd_val = r_reg.tvec;
			cdm_pkg::OFS_TRAP_PC:      rd_val = r_reg.tpc;
			cdm_pkg::OFS_TRAP_CAUSE:   rd_val = r_reg.tcause;
			cdm_pkg::OFS_IRQ_MASK:     rd_val = r_reg.irq_mask;
			cdm_pkg::OFS_DBG_CTRL:     rd_val = in_dbg ? dbg_ctrl_val : cdm_pkg::ZERO_WORD;
			cdm_pkg::OFS_DBG_PC:       rd_val = in_dbg ? r_reg.dpc : cdm_pkg::ZERO_WORD;
			cdm_pkg::OFS_DBG_SCRATCH0: rd_val = in_dbg ? r_reg.scratch0 : cdm_pkg::ZERO_WORD;
			cdm_pkg::OFS_DBG_SCRATCH1: rd_val = in_dbg ? r_reg.scratch1 : cdm_pkg::ZERO_WORD;
			// trigger reads work in every mode
			cdm_pkg::OFS_TRIG_FIRST:   rd_val = trig_first_val; // RL18
			cdm_pkg::OFS_TRIG_SECOND:  rd_val = r_reg.trig_addr;
			cdm_pkg::OFS_DBG_STATE:    rd_val = {29'h0000_0000, debug_halted,
				debug_running, debug_havereset};
			default:                   rd_val = cdm_pkg::ZERO_WORD;
		endcase
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		r_next = r_reg;
		r_next.redirect = 1'b0;
		r_next.irq_ack = 1'b0;
		instr_kill = 1'b0;

		// apb: data and error latched in setup, write lands in access
		if (acc_setup) begin
			r_next.prdata = pwrite ? cdm_pkg::ZERO_WORD : rd_val;
			r_next.pslverr = !is_mapped(paddr) || (is_dbg_reg(paddr) && !in_dbg); // RL17
		end
		if (wr_ok) begin
			unique case (paddr)
				cdm_pkg::OFS_TRAP_STATUS: begin
					// software re-enable is the only way to nest
					r_next.gie = pwdata[cdm_pkg::BIT_GIE]; // RL2
					r_next.pgie = pwdata[cdm_pkg::BIT_PGIE];
				end
				cdm_pkg::OFS_TRAP_VECTOR:  r_next.tvec = pwdata;
				cdm_pkg::OFS_TRAP_PC:      r_next.tpc = pwdata;
				cdm_pkg::OFS_TRAP_CAUSE:   r_next.tcause = pwdata;
				cdm_pkg::OFS_IRQ_MASK:     r_next.irq_mask = pwdata;
				// writable only here, so only from debug mode
				cdm_pkg::OFS_DBG_CTRL:     r_next.brk_dbg = pwdata[cdm_pkg::BIT_BRK_DBG]; // RL21
				// software steps this past a breakpoint before returning
				cdm_pkg::OFS_DBG_PC:       r_next.dpc = pwdata;
				cdm_pkg::OFS_DBG_SCRATCH0: r_next.scratch0 = pwdata;
				cdm_pkg::OFS_DBG_SCRATCH1: r_next.scratch1 = pwdata;
				cdm_pkg::OFS_TRIG_FIRST: begin
					// trigger writes are dropped silently outside debug
					if (in_dbg) begin
						r_next.trig_en = pwdata[cdm_pkg::BIT_TRIG_EXEC]; // RL18
					end
				end
				cdm_pkg::OFS_TRIG_SECOND: begin
					if (in_dbg) begin
						r_next.trig_addr = pwdata; // RL18
					end
				end
				default: begin
					// read-only state word: write has no effect
				end
			endcase
		end

		// hardware events come after the bus so they win in the same cycle
		unique case (r_reg.st)
			cdm_pkg::ST_RESET: begin
				// a request here is remembered for the availability edge
				if (debug_req) begin
					r_next.req_seen = 1'b1; // RL12
				end
				if (fetch_enable) begin
					// permit seen: count the fixed availability delay
					r_next.st = cdm_pkg::ST_BOOT; // RL10
					r_next.boot_cnt = '0;
				end
			end
			cdm_pkg::ST_BOOT: begin
				r_next.boot_cnt = r_reg.boot_cnt + 2'h1;
				if (r_reg.boot_cnt == cdm_pkg::BOOT_LAST) begin
					if (r_reg.req_seen || debug_req) begin
						// straight from unavailable into halted
						r_next.st = cdm_pkg::ST_HALT; // RL12
						r_next.dpc = instr_pc; // RL3
						r_next.dcause = cdm_pkg::DCAUSE_HALTREQ;
						r_next.redirect = 1'b1;
						r_next.target = halt_entry_address;
						instr_kill = 1'b1;
					end else begin
						r_next.st = cdm_pkg::ST_RUN; // RL11
					end
					r_next.req_seen = 1'b0;
				end else if (debug_req) begin
					r_next.req_seen = 1'b1; // RL12
				end
			end
			cdm_pkg::ST_RUN: begin
				if (debug_req || trig_hit || (instr_valid && instr_ebreak && r_reg.brk_dbg)) begin
					// the request is acted on in its first cycle, so the
					// decoded instruction is squashed before it executes
					r_next.st = cdm_pkg::ST_HALT; // RL4 RL13
					instr_kill = 1'b1; // RL8
					r_next.dpc = instr_pc; // RL3
					r_next.redirect = 1'b1;
					r_next.target = halt_entry_address; // RL3 RL20
					if (debug_req) begin
						r_next.dcause = cdm_pkg::DCAUSE_HALTREQ;
					end else if (trig_hit) begin
						r_next.dcause = cdm_pkg::DCAUSE_TRIGGER; // RL5
					end else begin
						r_next.dcause = cdm_pkg::DCAUSE_EBREAK; // RL20
					end
				end else if (instr_valid && (instr_ebreak || instr_exc)) begin
					// synchronous trap; the pipeline alone decides what is
					// illegal, nothing is added here for pc-relative code
					instr_kill = 1'b1; // RL6
					r_next.tpc = instr_pc; // RL23
					r_next.pgie = r_reg.gie; // RL23
					r_next.gie = 1'b0; // RL1
					// exception code zero-extended into the cause word
					r_next.tcause = cdm_pkg::XLEN'(
						instr_ebreak ? cdm_pkg::EXC_BREAKPOINT : instr_exc_code); // RL19
					r_next.redirect = 1'b1;
					r_next.target = vec_base; // RL19
				end else if (instr_valid && r_reg.gie && (|irq_pend)) begin
					// interrupt: vectored mode steps four bytes per index
					instr_kill = 1'b1;
					r_next.tpc = instr_pc; // RL23
					r_next.pgie = r_reg.gie; // RL23
					r_next.gie = 1'b0; // RL1
					r_next.tcause = cdm_pkg::ZERO_WORD;
					r_next.tcause[cdm_pkg::BIT_CAUSE_IRQ] = 1'b1;
					r_next.tcause[cdm_pkg::ID_W-1:0] = irq_pick(irq_pend);
					r_next.irq_ack = 1'b1;
					r_next.irq_id = irq_pick(irq_pend);
					r_next.redirect = 1'b1;
					// direct mode and all exceptions share the base
					r_next.target = r_reg.tvec[cdm_pkg::BIT_VEC_MODE] ?
						vec_base + (cdm_pkg::XLEN'(irq_pick(irq_pend)) << cdm_pkg::IRQ_STEP_SH) :
						vec_base;
				end else if (instr_valid && instr_mret) begin
					// trap return restores the enable and the pc
					r_next.gie = r_reg.pgie; // RL23
					r_next.pgie = 1'b1;
					r_next.redirect = 1'b1;
					r_next.target = r_reg.tpc; // RL23
				end
			end
			cdm_pkg::ST_HALT: begin
				// interrupts and halt requests have no effect here
				if (instr_valid && instr_dret) begin
					r_next.st = cdm_pkg::ST_RUN; // RL25
					r_next.redirect = 1'b1;
					r_next.target = r_reg.dpc; // RL25
				end else if (instr_valid && instr_ebreak) begin
					// restart the debug code, no register touched
					instr_kill = 1'b1;
					r_next.redirect = 1'b1;
					r_next.target = halt_entry_address; // RL14
				end else if (instr_valid && (instr_exc || instr_mret || instr_uret)) begin
					// status registers are left exactly as they were
					instr_kill = 1'b1;
					r_next.redirect = 1'b1;
					r_next.target = debug_trap_address; // RL15
				end
			end
		endcase
	end

	// ***************************************************************
	// registers
	// ***************************************************************

	// single clocked process for all state; synchronous reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_reg.st        <= cdm_pkg::ST_RESET; // RL10
			r_reg.boot_cnt  <= '0;
			r_reg.req_seen  <= 1'b0;
			r_reg.gie       <= 1'b0;
			r_reg.pgie      <= 1'b0;
			r_reg.tvec      <= cdm_pkg::ZERO_WORD;
			r_reg.tpc       <= cdm_pkg::ZERO_WORD;
			r_reg.tcause    <= cdm_pkg::ZERO_WORD;
			r_reg.irq_mask  <= cdm_pkg::ZERO_WORD;
			r_reg.brk_dbg   <= 1'b0; // RL21
			r_reg.dcause    <= '0;
			r_reg.dpc       <= cdm_pkg::ZERO_WORD;
			r_reg.scratch0  <= cdm_pkg::ZERO_WORD;
			r_reg.scratch1  <= cdm_pkg::ZERO_WORD;
			r_reg.trig_en   <= 1'b0;
			r_reg.trig_addr <= cdm_pkg::ZERO_WORD;
			r_reg.redirect  <= 1'b0;
			r_reg.target    <= cdm_pkg::ZERO_WORD;
			r_reg.irq_ack   <= 1'b0;
			r_reg.irq_id    <= '0;
			r_reg.prdata    <= cdm_pkg::ZERO_WORD;
			r_reg.pslverr   <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************

	// status decoded from one state field, so one-hot by construction
	assign debug_havereset   = (r_reg.st == cdm_pkg::ST_RESET) ||
		(r_reg.st == cdm_pkg::ST_BOOT); // RL9 RL10
	assign debug_running     = (r_reg.st == cdm_pkg::ST_RUN); // RL9 RL11
	assign debug_halted      = in_dbg; // RL9 RL11
	assign irq_global_enable = r_reg.gie;
	assign fetch_redirect    = r_reg.redirect;
	assign fetch_target      = r_reg.target;
	assign irq_ack           = r_reg.irq_ack;
	assign irq_id            = r_reg.irq_id;
	assign prdata            = r_reg.prdata;
	assign pslverr           = r_reg.pslverr && psel && penable;
	// zero wait state slave
	assign pready            = 1'b1;

endmodule

// ===== cdm_debug_ctrl_assertions.sv
/* checker for the debug state, entry and return of cdm_debug_ctrl.
   assumes one clock ref_clk with synchronous active high rst. */
`timescale 1ns/1ps
module cdm_debug_ctrl_assertions (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        fetch_enable,
	input wire logic        debug_req,
	input wire logic [31:0] halt_entry_address,
	input wire logic [31:0] debug_trap_address,
	input wire logic        instr_valid,
	input wire logic        instr_ebreak,
	input wire logic        instr_mret,
	input wire logic        instr_uret,
	input wire logic        instr_dret,
	input wire logic        instr_exc,
	input wire logic        instr_kill,
	input wire logic        fetch_redirect,
	input wire logic [31:0] fetch_target,
	input wire logic        irq_ack,
	input wire logic        debug_havereset,
	input wire logic        debug_running,
	input wire logic        debug_halted,
	input wire logic        irq_global_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	status_one_hot_a: assert property ($onehot({debug_havereset, debug_running, debug_halted}))
		else $error("status outputs not one-hot");
	reset_seen_a: assert property (disable iff (1'b0) rst |=> debug_havereset)
		else $error("reset status low in reset");
	boot_exit_a: assert property ($fell(debug_havereset) |-> $past(fetch_enable, 3))
		else $error("reset status fell without permit");
	halt_entry_a: assert property (debug_running && debug_req |-> instr_kill ##1
		(debug_halted && fetch_redirect && fetch_target == $past(halt_entry_address)))
		else $error("halt request not taken");
	debug_break_a: assert property (debug_halted && instr_valid && instr_ebreak |-> instr_kill ##1
		(debug_halted && fetch_redirect && fetch_target == $past(halt_entry_address)))
		else $error("breakpoint in debug misdirected");
	debug_trap_a: assert property (debug_halted && instr_valid && !instr_ebreak
		&& (instr_exc || instr_mret || instr_uret) |=> debug_halted && fetch_redirect
		&& fetch_target == $past(debug_trap_address)) else $error("debug trap misdirected");
	debug_return_a: assert property (debug_halted && instr_valid && instr_dret && !instr_ebreak
		&& !instr_exc |=> debug_running && fetch_redirect) else $error("debug return failed");
	irq_in_debug_a: assert property (debug_halted |=> !irq_ack)
		else $error("interrupt taken while halted");
	irq_disable_a: assert property ($rose(irq_ack) |-> !irq_global_enable ##1 !irq_ack)
		else $error("global enable kept on trap");
	cover property (debug_running && debug_req);
	cover property (irq_ack);
	cover property ($fell(debug_havereset) && debug_halted);
endmodule

bind cdm_debug_ctrl cdm_debug_ctrl_assertions u_chk (.*);

// ===== cdm_dm_model.sv
/* debug module stand-in: raises a halt request on go.
   assumes the halted status of the core as its only feedback. */
`timescale 1ns/1ps
module cdm_dm_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic debug_halted,
	output logic     debug_req = 1'b0
);
	// request held until halted is seen, never shorter than a cycle
	always @(posedge ref_clk) begin
		if (go) debug_req <= 1'b1;
		else if (debug_halted) debug_req <= 1'b0;
	end
endmodule

// ===== cdm_debug_ctrl_tb_top.sv
/* self-checking bench: apb register access, instruction events, halt requests.
   assumes cdm_pkg, the design, checker and debug module model are compiled. */
`timescale 1ns/1ps
module cdm_debug_ctrl_tb_top;
	logic ref_clk = 0, rst = 1, fetch_enable = 0, go = 0, debug_req, pready, pslverr;
	logic instr_valid = 0, instr_ebreak = 0, instr_dret = 0, instr_exc = 0;
	logic instr_mret = 0, instr_uret = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] instr_pc = 0, irq_lines = 0, pwdata = 0, prdata, fetch_target;
	logic [31:0] halt_entry_address = 32'h0000_1000, debug_trap_address = 32'h0000_2000;
	logic [7:0] paddr = 0;
	logic [4:0] instr_exc_code = 0, irq_id;
	logic instr_kill, fetch_redirect, irq_ack, debug_havereset, debug_running;
	logic debug_halted, irq_global_enable;
	int err_total = 0, checked = 0, acks = 0, bad = 0;
	cdm_debug_ctrl u_dut (.*);
	cdm_dm_model u_dm (.ref_clk, .go, .debug_halted, .debug_req);
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (irq_ack === 1'b1) acks++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, e,
		input logic ee);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk);
		while (pready !== 1'b1);
		if (!w) chk(prdata, e);
		chk({31'h0, pslverr}, {31'h0, ee});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// k is {exc, ebreak, dret, valid}, shown for one cycle
	task automatic ins(input logic [31:0] p, input logic [3:0] k);
		instr_pc <= p;
		{instr_exc, instr_ebreak, instr_dret, instr_valid} <= k;
		@(posedge ref_clk);
		{instr_exc, instr_ebreak, instr_dret, instr_valid} <= 4'h0;
		@(posedge ref_clk);
	endtask
	task automatic halt();
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		apb(0, 8'h2c, 0, 32'h1, 0);
		apb(0, 8'h14, 0, 0, 1);
		apb(0, 8'h40, 0, 0, 1);
		halt();
		fetch_enable <= 1'b1;
		repeat (8) begin
			@(posedge ref_clk);
			if (debug_running === 1'b1) bad = 1;
		end
		chk(bad, 0);
		apb(0, 8'h2c, 0, 32'h4, 0);
		apb(0, 8'h14, 0, 32'hc3, 0);
		apb(1, 8'h14, 32'h8000, 0, 0);
		apb(1, 8'h24, 32'h4, 0, 0);
		apb(1, 8'h28, 32'h100, 0, 0);
		apb(0, 8'h24, 0, 32'h2800_0004, 0);
		ins(32'h50, 4'h5);
		ins(32'h54, 4'h9);
		apb(0, 8'h18, 0, 0, 0);
		$display("debug entry tests done");
		ins(32'h0, 4'h3);
		apb(0, 8'h2c, 0, 32'h2, 0);
		apb(1, 8'h28, 32'h200, 0, 0);
		apb(0, 8'h28, 0, 32'h100, 0);
		ins(32'h100, 4'h1);
		apb(0, 8'h14, 0, 32'h8083, 0);
		apb(0, 8'h18, 0, 32'h100, 0);
		ins(32'h0, 4'h3);
		ins(32'h300, 4'h5);
		apb(0, 8'h14, 0, 32'h8043, 0);
		apb(0, 8'h18, 0, 32'h300, 0);
		apb(1, 8'h14, 0, 0, 0);
		apb(1, 8'h18, 32'h304, 0, 0);
		ins(32'h0, 4'h3);
		ins(32'h400, 4'h5);
		apb(0, 8'h2c, 0, 32'h2, 0);
		apb(0, 8'h08, 0, 32'h400, 0);
		apb(0, 8'h0c, 0, 32'h3, 0);
		$display("breakpoint tests done");
		apb(1, 8'h10, 32'h800, 0, 0);
		apb(1, 8'h00, 32'h8, 0, 0);
		irq_lines <= 32'h800;
		instr_pc <= 32'h500;
		instr_valid <= 1'b1;
		repeat (6) @(posedge ref_clk);
		instr_valid <= 1'b0;
		@(posedge ref_clk);
		chk(acks, 1);
		chk({27'h0, irq_id}, 32'hb);
		apb(0, 8'h00, 0, 32'h80, 0);
		apb(0, 8'h0c, 0, 32'h8000_000b, 0);
		halt();
		apb(1, 8'h00, 32'h8, 0, 0);
		ins(32'h504, 4'h1);
		chk(acks, 1);
		$display("interrupt tests done");
		close_out();
	end
endmodule
